// >>> include/twc_pkg.sv
// Constants and types of the two-wire master controller.
// Assumes a 50 MHz core clock and a 32-bit Avalon-MM register port.
package twc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int             ADDR_W      = 5;
  localparam int             DATA_W      = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE    = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CLKDIV  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_TXDATA  = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_RXDATA  = 5'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CB_START    = 0;
  localparam int CB_MSEN     = 2;
  localparam int CB_MASTER_DISABLE_BIT    = 3;
  localparam int CB_SWRST    = 7;
  localparam int MB_READ     = 12;
  localparam int MF_ADDR_LSB = 16;
  localparam int DEV_ADDR_W  = 7;
  localparam int CF_LOW_LSB  = 0;
  localparam int CF_HIGH_LSB = 8;
  localparam int CF_EXP_LSB  = 16;
  localparam int DIV_W       = 8;
  localparam int EXP_W       = 3;
  localparam int SB_TRANSFER_COMPLETE_FLAG   = 0;
  localparam int SB_RECEIVE_READY_FLAG    = 1;
  localparam int SB_TRANSMIT_READY_FLAG    = 2;
  localparam int SB_NOT_ACKNOWLEDGE_FLAG     = 8;
  localparam int SB_STUCK    = 9;
  localparam int BYTE_W      = 8;

  // ----------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------
  localparam int               CNT_W        = 16;
  localparam int               DIVIDE_LIMIT = 8191;
  localparam logic [2:0]       BIT_LAST     = 3'h7;
  localparam logic [2:0]       BIT_FIRST    = 3'h0;
  localparam logic             RST_TRANSFER_COMPLETE_FLAG   = 1'b1;
  localparam logic             RST_TRANSMIT_READY_FLAG    = 1'b1;
  localparam logic [DIV_W-1:0] RST_DIV      = 8'h00;
  localparam logic [EXP_W-1:0] RST_EXP      = 3'h0;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START,
    ST_BIT_LOW,
    ST_BIT_HIGH,
    ST_ACK_LOW,
    ST_ACK_HIGH,
    ST_STOP_LOW,
    ST_STOP_HIGH
  } twc_state_e;

endpackage

// >>> include/twc_phase_if.sv
// Link between the controller and its clock phase timer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface twc_phase_if;
  import twc_pkg::*;
  logic             load;
  logic [CNT_W-1:0] count;
  logic             run;
  logic             done;
  modport ctl (output load, output count, output run, input done);
  modport tmr (input load, input count, input run, output done);
endinterface

// >>> rtl/twc_phase_timer.sv
// Down counter timing one low or high phase of the serial clock.
// Assumes load and run come from logic on core_clk.
`timescale 1ns/1ps
module twc_phase_timer
  import twc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  twc_phase_if.tmr ph
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } tmr_s;

  tmr_s tmr_r;
  tmr_s tmr_nxt;

  always_comb
  begin
    tmr_nxt = tmr_r;
    if (ph.load)
      tmr_nxt.cnt = ph.count;
    else if (ph.run && tmr_r.cnt != '0)
      tmr_nxt.cnt = tmr_r.cnt - 1'b1;
  end

  // Count alone: the controller loads on done, so no path back from load
  assign ph.done = (tmr_r.cnt == '0);

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      tmr_r <= '0;
    else
      tmr_r <= tmr_nxt;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TMR_LOAD: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    ph.load |=> tmr_r.cnt == $past(ph.count))
    else $error("Phase timer did not take its count");

  AST_TMR_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (!ph.load && !ph.run) |=> $stable(tmr_r.cnt) && !$past(ph.done) || tmr_r.cnt == '0)
    else $error("Phase timer moved while stalled");

endmodule // twc_phase_timer

// >>> rtl/two_wire_controller.sv
// Two-wire bus master with Avalon-MM register port.
// Assumes open-drain pads outside; scl_in and sda_in are asynchronous.
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module two_wire_controller
  import twc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              scl_in,
  output logic                   scl_out,
  output logic                   scl_oe,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe
);

  typedef struct packed {
    logic                  scl_m;
    logic                  scl_s;
    logic                  sda_m;
    logic                  sda_s;
    logic                  ack;
    logic [DATA_W-1:0]     rdata;
    logic                  msen;
    logic                  stuck;
    logic                  start_req;
    logic                  read_dir;
    logic [DEV_ADDR_W-1:0] dev_addr;
    logic [DIV_W-1:0]      clock_low_divider;
    logic [DIV_W-1:0]      clock_high_divider;
    logic [EXP_W-1:0]      clock_prescale_exponent;
    logic [BYTE_W-1:0]     txdata;
    logic [BYTE_W-1:0]     rhr;
    logic [BYTE_W-1:0]     shifter;
    logic                  transfer_complete_flag;
    logic                  receive_ready_flag;
    logic                  transmit_ready_flag;
    logic                  not_acknowledge_flag;
    logic                  not_acknowledge_flag_pend;
    twc_state_e            state;
    logic [2:0]            bitn;
    logic                  data_phase;
    logic                  scl_drv;
    logic                  sda_drv;
  } ctl_s;

  ctl_s              ctl_r;
  ctl_s              ctl_nxt;
  logic              rd_cap;
  logic              wr_take;
  logic              recv;
  logic [CNT_W-1:0]  low_cnt;
  logic [CNT_W-1:0]  high_cnt;
  logic [DATA_W-1:0] status_word;

  twc_phase_if ph ();

  twc_phase_timer u_timer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .ph       (ph)
  );

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // Reads capture data and side effects on the first edge, writes act on the second
  assign avs_waitrequest = (avs_read || avs_write) && !ctl_r.ack;
  assign rd_cap          = avs_read && !ctl_r.ack;
  assign wr_take         = avs_write && ctl_r.ack;
  assign avs_readdata    = ctl_r.rdata;
  assign scl_out         = 1'b0;
  assign sda_out         = 1'b0;
  assign scl_oe          = ctl_r.scl_drv;
  assign sda_oe          = ctl_r.sda_drv;

  assign recv     = ctl_r.data_phase && ctl_r.read_dir;
  assign low_cnt  = {{(CNT_W-DIV_W){1'b0}}, ctl_r.clock_low_divider} << ctl_r.clock_prescale_exponent;
  assign high_cnt = {{(CNT_W-DIV_W){1'b0}}, ctl_r.clock_high_divider} << ctl_r.clock_prescale_exponent;

  always_comb
  begin
    status_word            = '0;
    status_word[SB_TRANSFER_COMPLETE_FLAG] = ctl_r.transfer_complete_flag;
    status_word[SB_RECEIVE_READY_FLAG]  = ctl_r.receive_ready_flag;
    status_word[SB_TRANSMIT_READY_FLAG]  = ctl_r.transmit_ready_flag;
    status_word[SB_NOT_ACKNOWLEDGE_FLAG]   = ctl_r.not_acknowledge_flag;
    status_word[SB_STUCK]  = ctl_r.stuck;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    ctl_nxt       = ctl_r;
    ph.load       = 1'b0;
    ph.count      = low_cnt;
    // Bit, acknowledge and stop high phases count only while the line is seen high
    ph.run        = ctl_r.msen &&
                    !((ctl_r.state == ST_BIT_HIGH || ctl_r.state == ST_ACK_HIGH ||
                       ctl_r.state == ST_STOP_HIGH) && !ctl_r.scl_s);
    ctl_nxt.scl_m = scl_in;
    ctl_nxt.scl_s = ctl_r.scl_m;
    ctl_nxt.sda_m = sda_in;
    ctl_nxt.sda_s = ctl_r.sda_m;
    ctl_nxt.ack   = (avs_read || avs_write) && !ctl_r.ack;

    // Register reads and their side effects
    if (rd_cap)
    begin
      case (avs_address)
        OFS_MODE:   ctl_nxt.rdata = {{(DATA_W-MF_ADDR_LSB-DEV_ADDR_W){1'b0}}, ctl_r.dev_addr,
                                     {(MF_ADDR_LSB-MB_READ-1){1'b0}}, ctl_r.read_dir,
                                     {MB_READ{1'b0}}};
        OFS_CLKDIV: ctl_nxt.rdata = {{(DATA_W-CF_EXP_LSB-EXP_W){1'b0}}, ctl_r.clock_prescale_exponent,
                                     ctl_r.clock_high_divider, ctl_r.clock_low_divider};
        OFS_STATUS:
        begin
          ctl_nxt.rdata     = status_word;
          ctl_nxt.not_acknowledge_flag      = 1'b0;
          ctl_nxt.not_acknowledge_flag_pend = 1'b0;
        end
        OFS_TXDATA: ctl_nxt.rdata = {{(DATA_W-BYTE_W){1'b0}}, ctl_r.txdata};
        OFS_RXDATA:
        begin
          ctl_nxt.rdata = {{(DATA_W-BYTE_W){1'b0}}, ctl_r.rhr};
          ctl_nxt.receive_ready_flag = 1'b0;
        end
        default:    ctl_nxt.rdata = '0;
      endcase
    end

    // Register writes
    if (wr_take)
    begin
      case (avs_address)
        OFS_CTRL:
        begin
          if (avs_writedata[CB_MSEN])
            ctl_nxt.msen = 1'b1;
          if (avs_writedata[CB_MASTER_DISABLE_BIT])
            ctl_nxt.msen = 1'b0;
          if (avs_writedata[CB_START])
            ctl_nxt.start_req = 1'b1;
        end
        OFS_MODE:
        begin
          ctl_nxt.read_dir = avs_writedata[MB_READ];
          ctl_nxt.dev_addr = avs_writedata[MF_ADDR_LSB +: DEV_ADDR_W];
        end
        OFS_CLKDIV:
        begin
          ctl_nxt.clock_low_divider = avs_writedata[CF_LOW_LSB +: DIV_W];
          ctl_nxt.clock_high_divider = avs_writedata[CF_HIGH_LSB +: DIV_W];
          ctl_nxt.clock_prescale_exponent = avs_writedata[CF_EXP_LSB +: EXP_W];
        end
        OFS_TXDATA:
        begin
          ctl_nxt.txdata = avs_writedata[BYTE_W-1:0];
          ctl_nxt.transmit_ready_flag  = 1'b0;
        end
        default: ;
      endcase
    end

    // Frame engine, held still while the master is disabled
    if (ctl_r.msen)
    begin
      case (ctl_r.state)
        ST_IDLE:
        begin
          if (ctl_r.start_req)
          begin
            ctl_nxt.start_req = 1'b0;
            if (!ctl_r.stuck)
            begin
              ctl_nxt.sda_drv    = 1'b1;
              ctl_nxt.state      = ST_START;
              ctl_nxt.data_phase = 1'b0;
              ctl_nxt.shifter    = {ctl_r.dev_addr, ctl_r.read_dir};
              ctl_nxt.bitn       = BIT_LAST;
              ctl_nxt.transfer_complete_flag     = 1'b0;
              ctl_nxt.not_acknowledge_flag_pend  = 1'b0;
              ph.load            = 1'b1;
              ph.count           = high_cnt;
            end
          end
        end
        ST_START:
        begin
          if (ph.done)
          begin
            ctl_nxt.scl_drv = 1'b1;
            ctl_nxt.state   = ST_BIT_LOW;
            ph.load         = 1'b1;
          end
        end
        ST_BIT_LOW:
        begin
          ctl_nxt.sda_drv = !recv && !ctl_r.shifter[BYTE_W-1];
          if (ph.done)
          begin
            ctl_nxt.scl_drv = 1'b0;
            ctl_nxt.state   = ST_BIT_HIGH;
            ph.load         = 1'b1;
            ph.count        = high_cnt;
          end
        end
        ST_BIT_HIGH:
        begin
          if (ph.done)
          begin
            ctl_nxt.shifter = {ctl_r.shifter[BYTE_W-2:0], ctl_r.sda_s};
            ctl_nxt.scl_drv = 1'b1;
            ph.load         = 1'b1;
            if (ctl_r.bitn == BIT_FIRST)
              ctl_nxt.state = ST_ACK_LOW;
            else
            begin
              ctl_nxt.bitn  = ctl_r.bitn - 1'b1;
              ctl_nxt.state = ST_BIT_LOW;
            end
          end
        end
        ST_ACK_LOW:
        begin
          // Released: the slave answers, or a single read byte is refused
          ctl_nxt.sda_drv = 1'b0;
          if (ph.done)
          begin
            ctl_nxt.scl_drv = 1'b0;
            ctl_nxt.state   = ST_ACK_HIGH;
            ph.load         = 1'b1;
            ph.count        = high_cnt;
          end
        end
        ST_ACK_HIGH:
        begin
          if (ph.done)
          begin
            ctl_nxt.scl_drv = 1'b1;
            ctl_nxt.rhr     = ctl_r.shifter;
            ph.load         = 1'b1;
            if (recv)
              ctl_nxt.receive_ready_flag = 1'b1;
            if (!recv && ctl_r.sda_s)
            begin
              ctl_nxt.not_acknowledge_flag_pend = 1'b1;
              ctl_nxt.state     = ST_STOP_LOW;
            end
            else if (ctl_r.data_phase)
              ctl_nxt.state = ST_STOP_LOW;
            else
            begin
              ctl_nxt.data_phase = 1'b1;
              ctl_nxt.bitn       = BIT_LAST;
              ctl_nxt.shifter    = ctl_r.txdata;
              ctl_nxt.state      = ST_BIT_LOW;
              if (!ctl_r.read_dir)
                ctl_nxt.transmit_ready_flag = 1'b1;
            end
          end
        end
        ST_STOP_LOW:
        begin
          ctl_nxt.sda_drv = 1'b1;
          if (ph.done)
          begin
            ctl_nxt.scl_drv = 1'b0;
            ctl_nxt.state   = ST_STOP_HIGH;
            ph.load         = 1'b1;
            ph.count        = high_cnt;
          end
        end
        ST_STOP_HIGH:
        begin
          if (ph.done)
          begin
            ctl_nxt.sda_drv   = 1'b0;
            ctl_nxt.transfer_complete_flag    = 1'b1;
            ctl_nxt.not_acknowledge_flag      = ctl_r.not_acknowledge_flag_pend;
            ctl_nxt.not_acknowledge_flag_pend = 1'b0;
            ctl_nxt.state     = ST_IDLE;
          end
        end
        default: ctl_nxt.state = ST_IDLE;
      endcase
    end

    // Software reset; a frame cut with the clock held low wedges the engine
    if (wr_take && avs_address == OFS_CTRL && avs_writedata[CB_SWRST])
    begin
      ctl_nxt.stuck      = ctl_r.stuck || (ctl_r.state != ST_IDLE && ctl_r.scl_drv);
      ctl_nxt.msen       = 1'b0;
      ctl_nxt.start_req  = 1'b0;
      ctl_nxt.read_dir   = 1'b0;
      ctl_nxt.dev_addr   = '0;
      ctl_nxt.clock_low_divider      = RST_DIV;
      ctl_nxt.clock_high_divider      = RST_DIV;
      ctl_nxt.clock_prescale_exponent      = RST_EXP;
      ctl_nxt.transfer_complete_flag     = RST_TRANSFER_COMPLETE_FLAG;
      ctl_nxt.transmit_ready_flag      = RST_TRANSMIT_READY_FLAG;
      ctl_nxt.receive_ready_flag      = 1'b0;
      ctl_nxt.not_acknowledge_flag       = 1'b0;
      ctl_nxt.not_acknowledge_flag_pend  = 1'b0;
      ctl_nxt.state      = ST_IDLE;
      ctl_nxt.data_phase = 1'b0;
      ctl_nxt.scl_drv    = 1'b0;
      ctl_nxt.sda_drv    = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_r        <= '0;
      ctl_r.transfer_complete_flag <= RST_TRANSFER_COMPLETE_FLAG;
      ctl_r.transmit_ready_flag  <= RST_TRANSMIT_READY_FLAG;
      ctl_r.state  <= ST_IDLE;
    end
    else
      ctl_r <= ctl_nxt;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  AST_STUCK_BLOCKS: assert property (
    (ctl_r.stuck && ctl_r.state == ST_IDLE) |=> ctl_r.state == ST_IDLE)
    else $error("Wedged controller began a frame");

  AST_SWRST_WEDGES: assert property (
    (wr_take && avs_address == OFS_CTRL && avs_writedata[CB_SWRST] &&
     ctl_r.state != ST_IDLE && ctl_r.scl_drv) |=> ctl_r.stuck && ctl_r.state == ST_IDLE)
    else $error("Reset with clock low did not wedge");

  AST_FREEZE: assert property (
    (!ctl_r.msen && !wr_take) |=> $stable(ctl_r.state) && $stable(ctl_r.scl_drv))
    else $error("Disabled engine moved");

  AST_DIS_KEEPS_FLAGS: assert property (
    (wr_take && avs_address == OFS_CTRL && avs_writedata[CB_MASTER_DISABLE_BIT] &&
     !avs_writedata[CB_SWRST]) |=> !ctl_r.msen && ctl_r.transfer_complete_flag == $past(ctl_r.transfer_complete_flag)
                                   && ctl_r.transmit_ready_flag == $past(ctl_r.transmit_ready_flag))
    else $error("Disable touched status flags");

  AST_NOT_ACKNOWLEDGE_FLAG_WITH_TRANSFER_COMPLETE_FLAG: assert property (
    $rose(ctl_r.not_acknowledge_flag) |-> $rose(ctl_r.transfer_complete_flag))
    else $error("Not-acknowledge rose without completion");

  AST_NOT_ACKNOWLEDGE_FLAG_CLEARS: assert property (
    (rd_cap && avs_address == OFS_STATUS && ctl_nxt.transfer_complete_flag == ctl_r.transfer_complete_flag) |=> !ctl_r.not_acknowledge_flag)
    else $error("Status read left not-acknowledge set");

  AST_NOT_ACKNOWLEDGE_FLAG_LOST: assert property (
    (rd_cap && avs_address == OFS_STATUS && ctl_r.not_acknowledge_flag_pend && ctl_r.state != ST_ACK_HIGH)
    |=> !ctl_r.not_acknowledge_flag_pend ##1 !ctl_r.not_acknowledge_flag[*3])
    else $error("Early status read did not drop not-acknowledge");

  AST_RHR_SILENT: assert property (
    (ctl_r.state == ST_ACK_HIGH && ph.done && ctl_r.msen && !recv && !wr_take)
    |=> ctl_r.rhr == $past(ctl_r.shifter) &&
        ctl_r.receive_ready_flag == $past(ctl_r.receive_ready_flag && !(rd_cap && avs_address == OFS_RXDATA)))
    else $error("Transmitted byte raised receive flag");

  AST_START_COND: assert property (
    (ctl_r.state == ST_IDLE && ctl_nxt.state == ST_START) |=> sda_oe && !scl_oe)
    else $error("Start condition malformed");

endmodule // two_wire_controller

// >>> dv/twc_slave_model.sv
// Behavioural two-wire slave for the controller bench.
// Assumes pulled-up lines resolved by the bench; pulls are active high.
`timescale 1ns/1ps
module twc_slave_model
(
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic        not_acknowledge_flag_data,
  input  wire logic [7:0]  rd_byte,
  input  wire logic [15:0] stretch_ns,
  output logic             sda_pull,
  output logic             scl_pull,
  output logic [7:0]       addr_byte,
  output logic [7:0]       data_byte,
  output int               frames
);
  logic [7:0] sh;

  initial
  begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    frames = 0;
  end

  // Slow answer: hold the clock low after each falling edge
  always @(negedge scl)
    if (stretch_ns != 16'h0000)
    begin
      scl_pull = 1'b1;
      #(stretch_ns);
      scl_pull = 1'b0;
    end

  task automatic get_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
  endtask

  // --------------------------------------------------------------
  // Frame decoder
  // --------------------------------------------------------------
  initial forever
  begin
    @(negedge sda iff scl === 1'b1);
    get_byte(sh);
    addr_byte = sh;
    @(negedge scl) sda_pull = 1'b1;
    if (sh[0])
    begin
      for (int i = 7; i >= 0; i--)
      begin
        @(negedge scl) sda_pull = ~rd_byte[i];
      end
      @(negedge scl) sda_pull = 1'b0;
    end
    else
    begin
      @(negedge scl) sda_pull = 1'b0;
      get_byte(sh);
      data_byte = sh;
      @(negedge scl) sda_pull = ~not_acknowledge_flag_data;
      @(negedge scl) sda_pull = 1'b0;
    end
    @(posedge sda iff scl === 1'b1);
    frames++;
  end
endmodule // twc_slave_model

// >>> dv/tb_two_wire_controller.sv
// Self-checking bench of the two-wire master controller.
// Assumes a pulled-up bus with one behavioural slave on it.
`timescale 1ns/1ps
module tb_two_wire_controller
  import twc_pkg::*;
;
  typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} note_s;
  logic              core_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata;
  logic              scl_oe, sda_oe, sda_pull, scl_pull, not_acknowledge_flag_data, dir, frz;
  logic [7:0]        rd_byte, addr_byte, data_byte, d, lo;
  logic [15:0]       stretch_ns;
  logic [6:0]        adr;
  logic [2:0]        ex;
  wire               scl_line = (scl_oe === 1'b1 || scl_pull) ? 1'b0 : 1'b1;
  wire               sda_line = (sda_oe === 1'b1 || sda_pull) ? 1'b0 : 1'b1;
  int                frames, fr0, n, fail_count, checks_done;
  note_s             notes[$];
  note_s             cur;

  two_wire_controller i_two_wire_controller (.core_clk(core_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_in(scl_line), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe));
  twc_slave_model i_twc_slave_model (.scl(scl_line), .sda(sda_line),
    .not_acknowledge_flag_data(not_acknowledge_flag_data), .rd_byte(rd_byte), .stretch_ns(stretch_ns),
    .sda_pull(sda_pull), .scl_pull(scl_pull), .addr_byte(addr_byte),
    .data_byte(data_byte), .frames(frames));

  // --------------------------------------------------------------
  // Checking and bus tasks
  // --------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge core_clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && notes.size() > 0)
    begin
      cur = notes.pop_front();
      check(cur.name, avs_readdata & cur.mask, cur.exp);
    end

  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= wd;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) check("waitrequest", 32'(avs_waitrequest), 32'h0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
  endtask

  task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    notes.push_back('{nm, e, 32'hffffffff});
    bus(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] st(input logic tc, rx, tr, nk, sk);
    return (32'(tc) << SB_TRANSFER_COMPLETE_FLAG) | (32'(rx) << SB_RECEIVE_READY_FLAG) | (32'(tr) << SB_TRANSMIT_READY_FLAG)
         | (32'(nk) << SB_NOT_ACKNOWLEDGE_FLAG) | (32'(sk) << SB_STUCK);
  endfunction

  task automatic cfg(input logic [7:0] l, input logic [7:0] h, input logic [2:0] e);
    wr(OFS_CLKDIV, (32'(e) << CF_EXP_LSB) | (32'(h) << CF_HIGH_LSB) | 32'(l));
    wr(OFS_CTRL, 32'h1 << CB_MSEN);
  endtask

  task automatic frame(input logic rdir);
    fr0 = frames;
    dir = rdir;
    adr = 7'($urandom);
    d = 8'($urandom);
    wr(OFS_MODE, (32'(rdir) << MB_READ) | (32'(adr) << MF_ADDR_LSB));
    if (!rdir) wr(OFS_TXDATA, 32'(d));
    wr(OFS_CTRL, 32'h1 << CB_START);
  endtask

  // Waits until the slave has seen the stop; status_mid, the frozen-frame read and the reset and swreset status reads do not follow it
  task automatic wait_frame();
    n = 0;
    while (frames == fr0 && n < 20000)
    begin
      @(posedge core_clk);
      n++;
    end
    check("frame_end", 32'(frames == fr0), 32'h0);
    repeat (4) @(posedge core_clk);
    check("addr_byte", 32'(addr_byte), 32'({adr, dir}));
  endtask

  task automatic count_scl(input int cyc, input logic lvl);
    n = 0;
    repeat (cyc)
    begin
      @(posedge core_clk);
      if (scl_oe !== lvl) n++;
    end
  endtask

  // --------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial
  begin
    #400000;
    check("watchdog", 32'h1, 32'h0);
    conclude();
  end

  initial
  begin
    {rst_b, avs_read, avs_write, not_acknowledge_flag_data} = 4'h0;
    {avs_address, avs_writedata, rd_byte, stretch_ns} = '0;
    n = $urandom(28599);
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    rd("status", OFS_STATUS, st(RST_TRANSFER_COMPLETE_FLAG, 1'b0, RST_TRANSMIT_READY_FLAG, 1'b0, 1'b0));
    rd("ctrl", OFS_CTRL, 32'h0);
    rd("unmapped", 5'h18, 32'h0);
    $display("test reset done");
    lo = 8'(1 + $urandom % 3);
    ex = 3'($urandom % 2);
    cfg(lo, 8'h02, ex);
    frame(1'b0);
    @(posedge scl_oe);
    @(posedge scl_oe);
    count_scl(1, 1'b1);
    n = 1;
    while (scl_oe === 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      n++;
    end
    check("low_phase", 32'(n - 1), 32'((lo << ex) + 1));
    wait_frame();
    check("data_byte", 32'(data_byte), 32'(d));
    rd("status", OFS_STATUS, st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    rd("rxdata", OFS_RXDATA, 32'(d));
    $display("test write done");
    cfg(8'h03, 8'h03, 3'h0);
    rd_byte = 8'($urandom);
    stretch_ns = 16'd300;
    frame(1'b1);
    wait_frame();
    stretch_ns = 16'd0;
    rd("status", OFS_STATUS, st(1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
    rd("rxdata_read", OFS_RXDATA, 32'(rd_byte));
    frame(1'b0);
    wait_frame();
    rd("rxdata", OFS_RXDATA, 32'(d));
    $display("test read done");
    not_acknowledge_flag_data = 1'b1;
    frame(1'b0);
    wait_frame();
    rd("status", OFS_STATUS, st(1'b1, 1'b0, 1'b1, 1'b1, 1'b0));
    rd("status", OFS_STATUS, st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    cfg(8'h04, 8'h04, 3'h0);
    frame(1'b0);
    repeat (18) @(posedge scl_line);
    repeat (10) @(posedge core_clk);
    notes.push_back('{"status_mid", st(1'b0, 1'b0, 1'b1, 1'b0, 1'b0), 32'hffffffff});
    bus(1'b0, OFS_STATUS, 32'h0);
    wait_frame();
    rd("status", OFS_STATUS, st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    not_acknowledge_flag_data = 1'b0;
    $display("test not_acknowledge_flag done");
    wr(OFS_CTRL, 32'h1 << CB_MASTER_DISABLE_BIT);
    rd("status", OFS_STATUS, st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    cfg(8'h03, 8'h03, 3'h0);
    frame(1'b0);
    repeat (100) @(posedge core_clk);
    wr(OFS_CTRL, 32'h1 << CB_MASTER_DISABLE_BIT);
    @(posedge core_clk);
    frz = scl_oe;
    count_scl(60, frz);
    check("frozen_scl", 32'(n), 32'h0);
    rd("status", OFS_STATUS, st(1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    wr(OFS_CTRL, 32'h1 << CB_MSEN);
    wait_frame();
    check("data_byte", 32'(data_byte), 32'(d));
    $display("test disable done");
    cfg(8'h06, 8'h06, 3'h0);
    frame(1'b0);
    @(posedge scl_oe);
    wr(OFS_CTRL, 32'h1 << CB_SWRST);
    rd("status", OFS_STATUS, st(1'b1, 1'b0, 1'b1, 1'b0, 1'b1));
    cfg(8'h06, 8'h06, 3'h0);
    wr(OFS_CTRL, 32'h1 << CB_START);
    count_scl(300, 1'b0);
    check("blocked_scl", 32'(n), 32'h0);
    check("sda_released", 32'(sda_oe), 32'h0);
    $display("test swreset done");
    conclude();
  end
endmodule // tb_two_wire_controller
